/* cmd_decoder.sv */
// digital command input decoder: pwm duty to signed command, steps to position
// assumes in1/in2 are asynchronous pins and an AXI4-Lite master on clk
//
// Behaviour
// - choose one-wire duty format centred at half, or two-wire full-range format
// - decoded duty is current command in current mode, velocity in velocity
// - one-wire: half duty gives zero, more positive, less negative
// - one-wire inversion swaps sign of command against duty
// - two-wire: magnitude from modulated input, sign from second input level
// - two-wire: zero duty zero command, full duty maximum, linear between
// - two-wire inversion makes magnitude fall as duty rises
// - failsafe option makes constant low or high input a zero command
// - position mode accepts pulse-direction, up-down or quadrature steps
// - option inverts direction of position change for every format
// - pulse-direction: one step per pulse in direction given by level
// - up-down: pulses on one input count up, other input count down
// - step formats advance on selectable rising or falling edge
// - each step moves position by a programmable gear count
// - quadrature from master encoder decoded to direction, scaled by gear
// - digital or analog source with zero accel passes position unfiltered
// - network, serial or program source with zero accel inhibits motion
`timescale 1ns/1ps
`default_nettype none

module cmd_decoder
  import cmd_decoder_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      arst_n,
  input  wire logic      in1,
  input  wire logic      in2,
  input  wire axil_req_t axilReq,
  output axil_rsp_t      axilRsp,
  output command_t       command,
  output logic [31:0]    positionCmd,
  output logic           motionInhibit,
  output logic           trajBypass
);

  // ******************************************
  // synchronisers
  // ******************************************
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] prev_reg;

  // two stages, then a history stage for edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      prev_reg  <= 2'h0;
    end else begin
      sync1_reg <= {in2, in1};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  logic a;
  logic b;
  logic aPrev;
  logic bPrev;
  assign a     = sync2_reg[0];
  assign b     = sync2_reg[1];
  assign aPrev = prev_reg[0];
  assign bPrev = prev_reg[1];

  // ******************************************
  // registers
  // ******************************************
  logic [31:0] ctrl_reg;
  logic [15:0] gear_reg;
  logic [15:0] accel_reg;

  mode_t     mode;
  step_fmt_t stepFmt;
  src_t      source;
  assign mode    = mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  assign stepFmt = step_fmt_t'(ctrl_reg[CTRL_STEPFMT_LSB +: 2]);
  assign source  = src_t'(ctrl_reg[CTRL_SRC_LSB +: 2]);

  logic twoWire;
  logic pwmInv;
  logic failsafe;
  logic dirInv;
  logic fallEdge;
  assign twoWire  = ctrl_reg[CTRL_PWMFMT_BIT];
  assign pwmInv   = ctrl_reg[CTRL_PWMINV_BIT];
  assign failsafe = ctrl_reg[CTRL_FAILSAFE_BIT];
  assign dirInv   = ctrl_reg[CTRL_DIRINV_BIT];
  assign fallEdge = ctrl_reg[CTRL_FALLEDGE_BIT];

  // ******************************************
  // duty measurement
  // ******************************************
  logic [CNT_W-1:0] highCnt_reg;
  logic [CNT_W-1:0] periodCnt_reg;
  logic [CNT_W-1:0] highLat_reg;
  logic [CNT_W-1:0] periodLat_reg;
  logic             periodDone_reg;
  logic             stuck_reg;

  logic aRise;
  assign aRise = a && !aPrev;

  // a period ends at each rising edge; a saturated count means a stuck line
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      highCnt_reg    <= '0;
      periodCnt_reg  <= '0;
      highLat_reg    <= '0;
      periodLat_reg  <= '0;
      periodDone_reg <= 1'b0;
      stuck_reg      <= 1'b0;
    end else begin
      periodDone_reg <= 1'b0;
      if (aRise) begin
        highLat_reg    <= highCnt_reg;
        periodLat_reg  <= periodCnt_reg;
        periodDone_reg <= 1'b1;
        stuck_reg      <= 1'b0;
        highCnt_reg    <= {{(CNT_W-1){1'b0}}, 1'b1};
        periodCnt_reg  <= {{(CNT_W-1){1'b0}}, 1'b1};
      end else if (periodCnt_reg == CNT_MAX) begin
        // no edge for a full count: report constant level as 0 or 100%
        highLat_reg    <= a ? CNT_MAX : '0;
        periodLat_reg  <= CNT_MAX;
        periodDone_reg <= 1'b1;
        stuck_reg      <= 1'b1;
        highCnt_reg    <= '0;
        periodCnt_reg  <= '0;
      end else begin
        periodCnt_reg <= periodCnt_reg + 1'b1;
        if (a) begin
          highCnt_reg <= highCnt_reg + 1'b1;
        end
      end
    end
  end

  // ******************************************
  // duty to command conversion
  // ******************************************
  // the divide is wide but runs once a period; kept combinational for clarity
  logic [CNT_W-1:0]        ratio;     // duty scaled to 0..CNT_MAX
  logic [2*CNT_W-1:0]      scaled;
  logic signed [CMD_W:0]   centred;
  logic signed [CMD_W-1:0] cmdNext;
  logic                    zeroDuty;
  logic                    fullDuty;

  always_comb begin
    scaled = '0;
    if (periodLat_reg != '0) begin
      scaled = ({highLat_reg, {CNT_W{1'b0}}} - {{CNT_W{1'b0}}, highLat_reg})
               / {{CNT_W{1'b0}}, periodLat_reg};
    end
    ratio    = scaled[CNT_W-1:0];
    zeroDuty = (highLat_reg == '0);
    fullDuty = (highLat_reg == periodLat_reg);
    cmdNext  = '0;
    if (twoWire) begin
      // magnitude linear in duty; inversion reflects it
      centred = {1'b0, (pwmInv ? ~ratio : ratio)} >>> 1;
      // sign from the static level on the second input
      cmdNext = b ? -centred[CMD_W-1:0] : centred[CMD_W-1:0];
    end else begin
      centred = $signed({1'b0, ratio}) - $signed(17'h08000);
      cmdNext = pwmInv ? -centred[CMD_W-1:0] : centred[CMD_W-1:0];
    end
    if (failsafe && (zeroDuty || fullDuty || stuck_reg)) begin
      cmdNext = '0;
    end
  end

  // command value updated once per measured period; mode flags every cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      command <= '0;
    end else begin
      if (periodDone_reg) begin
        command.value <= cmdNext;
      end
      command.currentValid  <= (mode == MODE_CURRENT);
      command.velocityValid <= (mode == MODE_VELOCITY);
    end
  end

  // ******************************************
  // step decode
  // ******************************************
  logic aEdge;
  logic bEdge;
  logic stepUp;
  logic stepDown;
  logic quadUp;
  logic quadDown;

  // selectable edge for step formats; quadrature uses every transition
  always_comb begin
    aEdge    = fallEdge ? (aPrev && !a) : (!aPrev && a);
    bEdge    = fallEdge ? (bPrev && !b) : (!bPrev && b);
    quadUp   = ((a ^ aPrev) && (a != b)) || ((b ^ bPrev) && (a == b));
    quadDown = ((a ^ aPrev) && (a == b)) || ((b ^ bPrev) && (a != b));
    stepUp   = 1'b0;
    stepDown = 1'b0;
    case (stepFmt)
      STEP_PULSE_DIR: begin
        stepUp   = aEdge && !b;
        stepDown = aEdge && b;
      end
      STEP_UP_DOWN: begin
        stepUp   = aEdge;
        stepDown = bEdge;
      end
      STEP_QUAD: begin
        // a glitch moving both phases at once is ignored
        stepUp   = quadUp && !quadDown;
        stepDown = quadDown && !quadUp;
      end
      default: begin
        stepUp   = 1'b0;
        stepDown = 1'b0;
      end
    endcase
    if (dirInv) begin
      {stepUp, stepDown} = {stepDown, stepUp};
    end
  end

  // ******************************************
  // position accumulation and source gating
  // ******************************************
  logic stepSource;
  logic accelZero;
  assign stepSource = (source == SRC_DIGITAL) || (source == SRC_ANALOG);
  assign accelZero  = (accel_reg == '0);

  // zero accel: pass through for step/analog, block motion otherwise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      positionCmd   <= '0;
      motionInhibit <= 1'b0;
      trajBypass    <= 1'b0;
    end else begin
      trajBypass    <= accelZero && stepSource;
      motionInhibit <= accelZero && !stepSource;
      if (mode == MODE_POSITION && stepSource) begin
        if (stepUp) begin
          positionCmd <= positionCmd + {16'h0, gear_reg};
        end else if (stepDown) begin
          positionCmd <= positionCmd - {16'h0, gear_reg};
        end
      end
    end
  end

  // ******************************************
  // axi4-lite slave
  // ******************************************
  logic        awHeld_reg;
  logic [7:0]  awAddr_reg;
  logic        wHeld_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;

  assign axilRsp.awready = !awHeld_reg && !axilRsp.bvalid;
  assign axilRsp.wready  = !wHeld_reg && !axilRsp.bvalid;
  assign axilRsp.arready = !axilRsp.rvalid;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  // address and data taken in either order, write once both are held
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_reg      <= 1'b0;
      awAddr_reg      <= '0;
      wHeld_reg       <= 1'b0;
      wData_reg       <= '0;
      wStrb_reg       <= '0;
      axilRsp.bvalid  <= 1'b0;
      axilRsp.bresp   <= 2'h0;
      ctrl_reg        <= CTRL_RESET;
      gear_reg        <= GEAR_RESET;
      accel_reg       <= ACCEL_RESET;
    end else begin
      if (axilReq.awvalid && axilRsp.awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= axilReq.awaddr;
      end
      if (axilReq.wvalid && axilRsp.wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= axilReq.wdata;
        wStrb_reg <= axilReq.wstrb;
      end
      if (awHeld_reg && wHeld_reg) begin
        awHeld_reg     <= 1'b0;
        wHeld_reg      <= 1'b0;
        axilRsp.bvalid <= 1'b1;
        axilRsp.bresp  <= 2'h0;
        case (awAddr_reg & 8'hfc)
          ADDR_CTRL:  ctrl_reg  <= merge(ctrl_reg, wData_reg, wStrb_reg);
          ADDR_GEAR:  gear_reg  <= 16'(merge({16'h0, gear_reg},
                                             wData_reg, wStrb_reg));
          ADDR_ACCEL: accel_reg <= 16'(merge({16'h0, accel_reg},
                                             wData_reg, wStrb_reg));
          ADDR_CMD, ADDR_POS, ADDR_STATUS: begin
            axilRsp.bresp <= 2'h0;   // read-only: write ignored
          end
          default:    axilRsp.bresp <= 2'h2;
        endcase
      end else if (axilRsp.bvalid && axilReq.bready) begin
        axilRsp.bvalid <= 1'b0;
      end
    end
  end

  // read data registered one cycle after the address is taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      axilRsp.rvalid <= 1'b0;
      axilRsp.rdata  <= '0;
      axilRsp.rresp  <= 2'h0;
    end else begin
      if (axilReq.arvalid && axilRsp.arready) begin
        axilRsp.rvalid <= 1'b1;
        axilRsp.rresp  <= 2'h0;
        case (axilReq.araddr & 8'hfc)
          ADDR_CTRL:   axilRsp.rdata <= ctrl_reg;
          ADDR_GEAR:   axilRsp.rdata <= {16'h0, gear_reg};
          ADDR_ACCEL:  axilRsp.rdata <= {16'h0, accel_reg};
          ADDR_CMD:    axilRsp.rdata <= {{16{command.value[CMD_W-1]}},
                                         command.value};
          ADDR_POS:    axilRsp.rdata <= positionCmd;
          ADDR_STATUS: axilRsp.rdata <= {26'h0, a, b, stuck_reg,
                                         trajBypass, motionInhibit,
                                         periodDone_reg};
          default: begin
            axilRsp.rdata <= '0;
            axilRsp.rresp <= 2'h2;
          end
        endcase
      end else if (axilRsp.rvalid && axilReq.rready) begin
        axilRsp.rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* cmd_decoder_pkg.sv */
// package for the digital command input decoder
// assumes a single 40 MHz clock domain and an AXI4-Lite register master
package cmd_decoder_pkg;

  // ******************************************
  // register map (byte addresses)
  // ******************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_GEAR   = 8'h04;
  localparam logic [7:0] ADDR_ACCEL  = 8'h08;
  localparam logic [7:0] ADDR_CMD    = 8'h0c;
  localparam logic [7:0] ADDR_POS    = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // ******************************************
  // control field positions
  // ******************************************
  localparam int CTRL_MODE_LSB    = 0;   // 2 bits: operating mode
  localparam int CTRL_PWMFMT_BIT  = 2;   // 0 one-wire, 1 two-wire
  localparam int CTRL_PWMINV_BIT  = 3;
  localparam int CTRL_FAILSAFE_BIT = 4;
  localparam int CTRL_STEPFMT_LSB = 5;   // 2 bits: step format
  localparam int CTRL_DIRINV_BIT  = 7;
  localparam int CTRL_FALLEDGE_BIT = 8;
  localparam int CTRL_SRC_LSB     = 9;   // 2 bits: command source

  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [15:0] GEAR_RESET  = 16'h0001;
  localparam logic [15:0] ACCEL_RESET = 16'h0000;

  // ******************************************
  // encodings
  // ******************************************
  typedef enum logic [1:0] {
    MODE_CURRENT  = 2'h0,
    MODE_VELOCITY = 2'h1,
    MODE_POSITION = 2'h2
  } mode_t;

  typedef enum logic [1:0] {
    STEP_PULSE_DIR = 2'h0,
    STEP_UP_DOWN   = 2'h1,
    STEP_QUAD      = 2'h2
  } step_fmt_t;

  typedef enum logic [1:0] {
    SRC_DIGITAL = 2'h0,
    SRC_ANALOG  = 2'h1,
    SRC_NETWORK = 2'h2,
    SRC_PROGRAM = 2'h3   // serial port or internal_program_engine
  } src_t;

  // pwm period counter width: periods up to 2^16 cycles (1.6 ms)
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
  localparam int CMD_W = 16;

  // ******************************************
  // carriers
  // ******************************************
  typedef struct packed {
    logic signed [CMD_W-1:0] value;
    logic                    currentValid;
    logic                    velocityValid;
  } command_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

endpackage

/* cmd_decoder_checker.sv */
// checker: port assertions for the command decoder
// assumes a single clk domain; bound onto every cmd_decoder
`timescale 1ns/1ps
`default_nettype none
module cmd_decoder_checker
  import cmd_decoder_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        in1,
  input wire logic        in2,
  input wire axil_req_t   axilReq,
  input wire axil_rsp_t   axilRsp,
  input wire command_t    command,
  input wire logic [31:0] positionCmd,
  input wire logic        motionInhibit,
  input wire logic        trajBypass
);
  // ****************
  // pin history
  // ****************
  logic        in1Q;
  logic        in2Q;
  logic [7:0]  pinHist;
  logic [15:0] riseAge;
  // recent pin changes, the only legal cause of a position step
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in1Q <= 1'b0;
      in2Q <= 1'b0;
      pinHist <= 8'h00;
    end else begin
      in1Q <= in1;
      in2Q <= in2;
      pinHist <= {pinHist[6:0], (in1 != in1Q) || (in2 != in2Q)};
    end
  end
  // age since in1 rose; saturates so a stuck input reads as old
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) riseAge <= 16'hffff;
    else if (in1 && !in1Q) riseAge <= 16'h0000;
    else if (riseAge != 16'hffff) riseAge <= riseAge + 16'h0001;
  end
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_mode_onehot: assert property (
    !(command.currentValid && command.velocityValid))
    else $error("current and velocity flags together");
  a_flags_excl: assert property (
    !(motionInhibit && trajBypass)) else $error("inhibit with bypass");
  a_pos_frozen: assert property (
    command.currentValid && $past(command.currentValid)
    |-> $stable(positionCmd)) else $error("position moved in current mode");
  a_pos_after_pin: assert property (
    $changed(positionCmd) |-> pinHist[7:2] != 8'h00)
    else $error("position step without synced pin change");
  a_cmd_per_period: assert property (
    $changed(command.value) |-> riseAge inside {[16'h2:16'hc]}
    || riseAge >= 16'hf000) else $error("command changed mid period");
  a_b_latency: assert property (
    axilReq.awvalid && axilRsp.awready && axilReq.wvalid && axilRsp.wready
    |=> !axilRsp.bvalid ##1 axilRsp.bvalid) else $error("bvalid late");
  a_r_latency: assert property (
    axilReq.arvalid && axilRsp.arready |=> axilRsp.rvalid)
    else $error("rvalid late");
  a_r_holds: assert property (
    axilRsp.rvalid && !axilReq.rready
    |=> axilRsp.rvalid && $stable(axilRsp.rdata)) else $error("rdata lost");
  a_ar_blocked: assert property (
    axilRsp.rvalid |-> !axilRsp.arready) else $error("arready during read");
  c_pos_move: cover property ($changed(positionCmd));
  c_cmd_update: cover property ($changed(command.value));
  c_read_stall: cover property (axilRsp.rvalid && !axilReq.rready);
endmodule
bind cmd_decoder cmd_decoder_checker cmd_decoder_checker_i (
  .clk(clk), .arst_n(arst_n), .in1(in1), .in2(in2), .axilReq(axilReq),
  .axilRsp(axilRsp), .command(command), .positionCmd(positionCmd),
  .motionInhibit(motionInhibit), .trajBypass(trajBypass));
`default_nettype wire

/* cmd_partner.sv */
// partner: motion controller or master encoder on in1/in2
// assumes tasks are called just after a rising clk edge
`timescale 1ns/1ps
`default_nettype none
module cmd_partner (
  input  wire logic clk,
  output var logic  in1,
  output var logic  in2
);
  // ****************
  // pin drivers
  // ****************
  initial begin
    in1 = 1'b0;
    in2 = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // static level; 4 clk keeps every phase past the synchroniser
  task automatic set(input logic onB, input logic v);
    if (onB) in2 <= v;
    else in1 <= v;
    hold(4);
  endtask
  // one whole pulse per step
  task automatic pulse(input logic onB, input int n);
    repeat (n) begin
      set(onB, 1'b1);
      set(onB, 1'b0);
    end
  endtask
  // fixed period burst, sign level held steady throughout
  task automatic pwm(input int h, input int p, input int n, input logic sgn);
    in2 <= sgn;
    repeat (n) begin
      in1 <= 1'b1;
      hold(h);
      in1 <= 1'b0;
      hold(p - h);
    end
  endtask
  // quadrature: a leading b counts up, one pin moves at a time
  task automatic quad(input int n, input logic up);
    repeat (n) begin
      if ((in1 == in2) == up) in1 <= ~in1;
      else in2 <= ~in2;
      hold(4);
    end
  endtask
endmodule
`default_nettype wire

/* cmd_decoder_tb.sv */
// testbench: random and corner traffic through registers and pins
// assumes cmd_partner drives the pins and the checker is bound
`timescale 1ns/1ps
`default_nettype none
module cmd_decoder_tb
  import cmd_decoder_pkg::*;
;
  logic        clk;
  logic        arst_n;
  logic        dir;
  wire logic   in1;
  wire logic   in2;
  logic        motionInhibit;
  logic        trajBypass;
  axil_req_t   req;
  axil_rsp_t   rsp;
  command_t    command;
  logic [31:0] positionCmd;
  logic [31:0] expPos;
  logic [31:0] d;
  logic [1:0]  r;
  int          nMismatch;
  int          totalChecks;
  int          cycles;
  int          h;
  int          g;
  int          n;
  int          e;
  cmd_decoder cmd_decoder_i (.clk(clk), .arst_n(arst_n), .in1(in1),
    .in2(in2), .axilReq(req), .axilRsp(rsp), .command(command),
    .positionCmd(positionCmd), .motionInhibit(motionInhibit),
    .trajBypass(trajBypass));
  cmd_partner cmd_partner_i (.clk(clk), .in1(in1), .in2(in2));
  // ****************
  // helpers
  // ****************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic report_and_stop();
    if (nMismatch == 0 && totalChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // a hung handshake ends here instead of running forever
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      nMismatch++;
      report_and_stop();
    end
  end
  task automatic check(input string w, input logic [31:0] s, x);
    totalChecks++;
    if (s !== x) begin
      nMismatch++;
      $display("FAIL %s expected %h seen %h", w, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        r = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
    end
  endtask
  // rready comes a cycle late on purpose to stall the slave
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    forever begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid && req.rready) begin
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        break;
      end
      if (rsp.rvalid) req.rready <= 1'b1;
    end
  endtask
  function automatic logic [31:0] cw(input logic [1:0] m, input logic tw,
    input logic iv, fs, input logic [1:0] f, input logic di, fe,
    input logic [1:0] s);
    return 32'(m) << CTRL_MODE_LSB | 32'(tw) << CTRL_PWMFMT_BIT
      | 32'(iv) << CTRL_PWMINV_BIT | 32'(fs) << CTRL_FAILSAFE_BIT
      | 32'(f) << CTRL_STEPFMT_LSB | 32'(di) << CTRL_DIRINV_BIT
      | 32'(fe) << CTRL_FALLEDGE_BIT | 32'(s) << CTRL_SRC_LSB;
  endfunction
  // rounding inside the divider is open, so allow a small band
  function automatic int pwmExp(input int h, p, input logic tw, iv, ng);
    int q;
    q = h * 65535 / p;
    if (!tw) return iv ? 32768 - q : q - 32768;
    q = iv ? (65535 - q) / 2 : q / 2;
    return ng ? -q : q;
  endfunction
  function automatic logic near(input logic signed [15:0] v, input int x);
    return (v >= x - 40) && (v <= x + 40);
  endfunction
  // ****************
  // main sequence
  // ****************
  initial begin
    arst_n = 1'b0;
    req = '0;
    void'($urandom(32'ha24f));
    repeat (12) @(posedge clk);
    check("awready in reset", {31'h0, rsp.awready}, 32'h1);
    arst_n <= 1'b1;
    rd(ADDR_CTRL);
    check("ctrl reset", d, CTRL_RESET);
    rd(ADDR_GEAR);
    check("gear reset", d, {16'h0, GEAR_RESET});
    rd(ADDR_ACCEL);
    check("accel reset", d, {16'h0, ACCEL_RESET});
    rd(8'h40);
    check("unmapped resp", {30'h0, r}, 32'h2);
    check("unmapped data", d, 32'h0);
    wr(ADDR_STATUS, 32'hffffffff);
    check("status write resp", {30'h0, r}, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CTRL, cw(MODE_POSITION, 1'($urandom), 1'($urandom),
        1'($urandom), '0, '0, '0, s[1:0]));
      cmd_partner_i.hold(3);
      check("bypass", {31'h0, trajBypass}, {31'h0, s < 2});
      check("inhibit", {31'h0, motionInhibit}, {31'h0, s > 1});
    end
    cmd_partner_i.pulse(1'b0, 3);
    check("inhibited position", positionCmd, 32'h0);
    wr(ADDR_ACCEL, 32'h5);
    cmd_partner_i.hold(3);
    check("inhibit released", {31'h0, motionInhibit}, 32'h0);
    for (int k = 0; k < 8; k++) begin
      h = (k == 0) ? 100 : $urandom_range(10, 190);
      dir = 1'($urandom);
      wr(ADDR_CTRL, cw({1'b0, k[0]}, k[1], k[2], '0, '0, '0, '0, '0));
      cmd_partner_i.pwm(h, 200, 3, dir);
      e = pwmExp(h, 200, k[1], k[2], dir);
      check("pwm", {31'h0, near(command.value, e)}, 32'h1);
      check("current", {31'h0, command.currentValid}, {31'h0, !k[0]});
      check("velocity", {31'h0, command.velocityValid}, {31'h0, k[0]});
    end
    wr(ADDR_CTRL, cw(MODE_CURRENT, 1'($urandom), 1'($urandom), 1'b1,
      2'($urandom_range(0, 2)), 1'($urandom), '0, '0));
    cmd_partner_i.set(1'b0, 1'b1);
    cmd_partner_i.hold(66000);
    check("failsafe", {16'h0, command.value}, 32'h0);
    cmd_partner_i.set(1'b0, 1'b0);
    g = $urandom_range(1, 7);
    wr(ADDR_GEAR, 32'(g));
    expPos = 32'h0;
    for (int k = 0; k < 6; k++) begin
      n = $urandom_range(1, 5);
      dir = 1'($urandom);
      wr(ADDR_CTRL, cw(MODE_POSITION, '0, '0, '0, 2'(k % 3), k > 2, '0, '0));
      case (k % 3)
        0: begin
          cmd_partner_i.set(1'b1, dir);
          cmd_partner_i.pulse(1'b0, n);
        end
        1: cmd_partner_i.pulse(dir, n);
        default: begin
          cmd_partner_i.quad(4 * n, !dir);
          n = 4 * n;
        end
      endcase
      cmd_partner_i.hold(8);
      expPos += ((dir ^ (k > 2)) ? -n : n) * g;
      check("position", positionCmd, expPos);
      cmd_partner_i.set(1'b1, 1'b0);
    end
    for (int f = 0; f < 2; f++) begin
      wr(ADDR_CTRL, cw(MODE_POSITION, '0, '0, '0, '0, '0, f[0], '0));
      cmd_partner_i.set(1'b0, 1'b1);
      cmd_partner_i.hold(4);
      check("step on rise", positionCmd, expPos + (f ? 0 : g));
      cmd_partner_i.set(1'b0, 1'b0);
      cmd_partner_i.hold(4);
      expPos += g;
      check("step on fall", positionCmd, expPos);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
